// File: sce_consts.svh
// constants of the upper-opcode execution block: opcodes, register numbers,
// field positions, reset values and multiply timing.
// assumes inclusion by bare name from the package and the design modules.
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH

// instruction byte fields
`define SCE_OPC_MSB 7
`define SCE_OPC_LSB 4
`define SCE_SEL_MSB 3
`define SCE_SEL_LSB 0

// operation codes (upper nibble)
`define SCE_OPC_CLEAR 4'h1
`define SCE_OPC_ASR 4'h7
`define SCE_OPC_INC 4'h8
`define SCE_OPC_DEC 4'h9
`define SCE_OPC_NOT 4'hA
`define SCE_OPC_BNN 4'hB
`define SCE_OPC_BNZ 4'hC
`define SCE_OPC_PRD 4'hD
`define SCE_OPC_PWR 4'hE
`define SCE_OPC_MUL 4'hF

// register field of a valid multiply
`define SCE_MUL_SEL 4'h3

// dedicated cpu register numbers
`define SCE_R_PC 4'h0
`define SCE_R_ACC 4'h1
`define SCE_R_MCAND 4'h3
`define SCE_R_MPLIER 4'h4
`define SCE_R_INDEX 5

// sign bit of a data word
`define SCE_SIGN_BIT 15

// reset values
`define SCE_RESET_WORD 16'h0000
`define SCE_PC_RESET 16'h0000

// multiply iterations
`define SCE_MUL_CYCLES 16

`endif

// File: sce_exec.sv
// execution of the upper opcodes of a small 16-bit sensor cpu: arithmetic right shift,
// increment, decrement, complement, two conditional branches, port moves
// and a sixteen-step multiply.
// assumes instr_byte is the program byte at fetch_addr whenever instr_valid
// is high, and that all inputs are synchronous to clk_sys.
`timescale 1ns/1ns
`include "sce_consts.svh"

module sce_exec import sce_pkg::*; #(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // instruction fetch
  output logic [DW-1:0] fetch_addr,
  input wire logic [7:0] instr_byte,
  input wire logic instr_valid,
  // execution status
  output logic busy,
  output logic op_unhandled,
  // port write notification
  output logic port_wr_stb,
  output logic [3:0] port_wr_idx,
  output logic [DW-1:0] port_wr_data,
  // observation of registers and ports
  input wire logic [3:0] dbg_reg_sel,
  input wire logic [3:0] dbg_port_sel,
  output logic [DW-1:0] dbg_reg_data,
  output logic [DW-1:0] dbg_port_data
);

  generate
    if (DW != 16) begin : g_bad_width
      $error("sce_exec: data width must be 16");
    end
  endgenerate

  // register 0 lives in fetch_addr; entries 1..15 here
  logic [DW-1:0] regs [1:15];
  logic [DW-1:0] ports [0:15];
  sce_state_t state;

  sce_op_t opc;
  logic [3:0] sel;
  logic [DW-1:0] xval;
  logic [DW-1:0] index_val;
  logic take;
  logic issue;
  logic mul_start;
  logic mul_done;
  logic [DW-1:0] mul_hi;
  logic [DW-1:0] mul_lo;
  logic reg_we;
  logic [DW-1:0] reg_wdata;
  logic [DW-1:0] next_pc;
  logic unhandled;

  // read of any cpu register, r0 being the program pointer
  function automatic logic [DW-1:0] reg_read(input logic [3:0] n);
    if (n == `SCE_R_PC) begin
      return fetch_addr;
    end
    return regs[n];
  endfunction

  // sequential advance of the pointer
  function automatic logic [DW-1:0] pc_step(input logic [DW-1:0] pc);
    return pc + DW'(1);
  endfunction

  assign opc = sce_op_t'(instr_byte[`SCE_OPC_MSB:`SCE_OPC_LSB]);
  assign sel = instr_byte[`SCE_SEL_MSB:`SCE_SEL_LSB];
  // process, not assign, so a write to the same register is seen at once
  always_comb begin
    xval = reg_read(sel);
  end
  assign index_val = regs[`SCE_R_INDEX];
  assign issue = instr_valid && (state == SCE_RUN);
  // a multiply with a foreign register field is treated as unsupported
  assign mul_start = issue && (opc == multiply_op) && (sel == `SCE_MUL_SEL);

  // branch condition from the index register
  always_comb begin
    take = 1'b0;
    if (opc == branch_nonnegative_op) begin
      take = !index_val[`SCE_SIGN_BIT];
    end else if (opc == branch_nonzero_op) begin
      take = (index_val != '0);
    end
  end

  // single-cycle result and next pointer
  always_comb begin
    reg_we = 1'b0;
    reg_wdata = xval;
    next_pc = fetch_addr;
    unhandled = 1'b0;
    if (issue) begin
      next_pc = pc_step(fetch_addr);
      unique case (opc)
        arith_shift_right_op: begin
          reg_we = 1'b1;
          reg_wdata = {xval[DW-1], xval[DW-1:1]};
        end
        increment_reg_op: begin
          reg_we = 1'b1;
          reg_wdata = xval + DW'(1);
        end
        decrement_reg_op: begin
          reg_we = 1'b1;
          reg_wdata = xval - DW'(1);
        end
        complement_reg_op: begin
          reg_we = 1'b1;
          reg_wdata = ~xval;
        end
        branch_nonnegative_op, branch_nonzero_op: begin
          // wraps mod 2^16, so a negative offset jumps backward
          if (take) begin
            next_pc = fetch_addr + xval;
          end
        end
        port_read_op, port_write_op: begin
        end
        multiply_op: begin
          // pointer holds during the multiply, advanced at write-back
          if (sel == `SCE_MUL_SEL) begin
            next_pc = fetch_addr;
          end else begin
            unhandled = 1'b1;
          end
        end
        default: begin
          unhandled = 1'b1; // lower opcodes belong to another unit
        end
      endcase
    end else if (mul_done) begin
      next_pc = pc_step(fetch_addr);
    end
  end

  // program pointer; a write to r0 by an op overrides the advance
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fetch_addr <= `SCE_PC_RESET;
    end else if (reg_we && sel == `SCE_R_PC) begin
      fetch_addr <= reg_wdata;
    end else begin
      fetch_addr <= next_pc;
    end
  end

  // general registers r1..r15
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 1; i < 16; i++) begin
        regs[i] <= `SCE_RESET_WORD;
      end
    end else if (mul_done) begin
      regs[`SCE_R_ACC] <= mul_hi;
      regs[`SCE_R_MPLIER] <= mul_lo;
    end else if (reg_we && sel != `SCE_R_PC) begin
      regs[sel] <= reg_wdata;
    end else if (issue && opc == port_read_op) begin
      regs[`SCE_R_ACC] <= ports[sel];
    end
  end

  // cpu ports and the write notification
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        ports[i] <= `SCE_RESET_WORD;
      end
      port_wr_stb <= 1'b0;
      port_wr_idx <= 4'h0;
      port_wr_data <= `SCE_RESET_WORD;
    end else begin
      port_wr_stb <= issue && (opc == port_write_op);
      if (issue && opc == port_write_op) begin
        ports[sel] <= regs[`SCE_R_ACC];
        port_wr_idx <= sel;
        port_wr_data <= regs[`SCE_R_ACC];
      end
    end
  end

  // execution state and status outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= SCE_RUN;
      busy <= 1'b0;
      op_unhandled <= 1'b0;
    end else begin
      op_unhandled <= unhandled;
      unique case (state)
        SCE_RUN: begin
          if (mul_start) begin
            state <= SCE_MUL;
            busy <= 1'b1;
          end
        end
        SCE_MUL: begin
          if (mul_done) begin
            state <= SCE_RUN;
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // observation, one cycle behind the select
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dbg_reg_data <= `SCE_RESET_WORD;
      dbg_port_data <= `SCE_RESET_WORD;
    end else begin
      dbg_reg_data <= reg_read(dbg_reg_sel);
      dbg_port_data <= ports[dbg_port_sel];
    end
  end

  // accumulator seeds the upper word; the program must have cleared it
  sce_mult #(
    .W(`SCE_MUL_CYCLES)
  ) u_mult (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(mul_start),
    .a_in(regs[`SCE_R_ACC]),
    .m_in(regs[`SCE_R_MPLIER]),
    .n_in(regs[`SCE_R_MCAND]),
    .done(mul_done),
    .hi(mul_hi),
    .lo(mul_lo)
  );

endmodule

// File: sce_exec_checker.sv
// checker for the upper-opcode block: pointer, strobes, busy, faults.
// assumes it is bound to sce_exec and sees only its ports.
`timescale 1ns/1ns
module sce_exec_checker(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // fetch and status
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] instr_byte,
  input wire logic instr_valid,
  input wire logic busy,
  input wire logic op_unhandled,
  // port write
  input wire logic port_wr_stb,
  input wire logic [3:0] port_wr_idx
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic tk, unh, step;
  logic [3:0] op;
  // taken byte and its class; a byte offered while busy is not taken
  assign tk = instr_valid && !busy;
  assign op = instr_byte[7:4];
  assign unh = op < 4'h7 || (op == 4'hF && instr_byte[3:0] != 4'h3);
  assign step = (op >= 4'h7 && op <= 4'hA && instr_byte[3:0] != 4'h0)
    || op == 4'hD || op == 4'hE || unh;
  a_pc_step: assert property (tk && step |=> fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("pointer did not advance by one");
  a_wr_strobe: assert property (tk && op == 4'hE |=> port_wr_stb
    && port_wr_idx == $past(instr_byte[3:0])) else $error("port write not flagged");
  a_stb_cause: assert property (port_wr_stb |-> $past(tk && op == 4'hE))
    else $error("stray port write strobe");
  a_mul_busy: assert property (tk && instr_byte == 8'hF3 |=> busy [*8] ##1 busy [*8] ##1 !busy)
    else $error("multiply length wrong");
  a_mul_pc: assert property (tk && instr_byte == 8'hF3 |-> ##17
    fetch_addr == $past(fetch_addr, 17) + 16'h0001) else $error("pointer after multiply");
  a_unh_pulse: assert property (tk && unh |=> op_unhandled)
    else $error("unhandled code not flagged");
  a_unh_cause: assert property (op_unhandled |-> $past(tk && unh))
    else $error("stray unhandled pulse");
  a_quiet_busy: assert property (busy && $past(busy) |-> !port_wr_stb && !op_unhandled)
    else $error("activity while busy");
endmodule

// File: sce_exec_tb.sv
// self-checking bench for the upper-opcode execution block.
// assumes sce_prog_mem as fetch partner and the checker bound below.
`timescale 1ns/1ns
module sce_exec_tb import sce_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic run = 1'b0;
  logic [3:0] dbg_reg_sel = 4'h0;
  logic [3:0] dbg_port_sel = 4'h0;
  logic [15:0] fetch_addr, dbg_reg_data, dbg_port_data, port_wr_data;
  logic [7:0] instr_byte;
  logic instr_valid, busy, op_unhandled, port_wr_stb;
  logic [3:0] port_wr_idx;
  logic [15:0] epc = 16'h0000;
  int num_errors = 0;
  int tests_run = 0;
  always #10 clk_sys = ~clk_sys;
  sce_prog_mem pm(.addr(fetch_addr), .run(run), .ibyte(instr_byte), .valid(instr_valid));
  sce_exec dut(.clk_sys(clk_sys), .rst_b(rst_b), .fetch_addr(fetch_addr),
    .instr_byte(instr_byte), .instr_valid(instr_valid), .busy(busy),
    .op_unhandled(op_unhandled), .port_wr_stb(port_wr_stb), .port_wr_idx(port_wr_idx),
    .port_wr_data(port_wr_data), .dbg_reg_sel(dbg_reg_sel), .dbg_port_sel(dbg_port_sel),
    .dbg_reg_data(dbg_reg_data), .dbg_port_data(dbg_port_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // byte placed at the expected pointer; run stays up so ops go back to back
  task automatic op(input logic [7:0] b);
    pm.mem[epc[7:0]] = b;
    run = 1'b1;
    @(negedge clk_sys);
    epc = epc + 16'h0001;
  endtask
  // observation has one edge of latency; stops issue first
  task automatic rd(input logic [3:0] r, input logic [3:0] p, output logic [15:0] rv,
    output logic [15:0] pv);
    run = 1'b0;
    dbg_reg_sel = r;
    dbg_port_sel = p;
    @(negedge clk_sys);
    rv = dbg_reg_data;
    pv = dbg_port_data;
  endtask
  task automatic reg_is(input logic [3:0] r, input logic [15:0] exp);
    logic [15:0] rv, pv;
    rd(r, 4'h0, rv, pv);
    chk(rv, exp);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // dec/inc wrap, complement, shift of a negative value
  task automatic t_alu;
    logic [7:0] prog [7] = '{8'h92, 8'h8F, 8'hA3, 8'h97, 8'h97, 8'h77, 8'h82};
    foreach (prog[i]) op(prog[i]);
    reg_is(4'h0, 16'h0007);
    reg_is(4'h2, 16'h0000);
    reg_is(4'hF, 16'h0001);
    reg_is(4'h3, 16'hFFFF);
    reg_is(4'h7, 16'hFFFF);
    reg_is(4'h1, 16'h0000);
  endtask
  task automatic t_port;
    logic [15:0] rv, pv;
    op(8'h91);
    op(8'hE5);
    chk({15'h0000, port_wr_stb}, 16'h0001);
    chk({12'h000, port_wr_idx}, 16'h0005);
    chk(port_wr_data, 16'hFFFF);
    op(8'h81);
    chk({15'h0000, port_wr_stb}, 16'h0000);
    op(8'hD5);
    rd(4'h1, 4'h5, rv, pv);
    chk(rv, 16'hFFFF);
    chk(pv, 16'hFFFF);
    op(8'h81);
  endtask
  // offset register 3 holds minus one, so taken branches go backward
  task automatic t_branch;
    op(8'hC3);
    reg_is(4'h0, epc);
    op(8'hB3);
    epc = epc - 16'h0002;
    reg_is(4'h0, epc);
    op(8'h95);
    op(8'hC3);
    epc = epc - 16'h0002;
    reg_is(4'h0, epc);
    op(8'hB3);
    reg_is(4'h0, epc);
  endtask
  // byte held valid through busy: a re-issue would show in the pointer
  task automatic t_mul;
    int n;
    reg_is(4'h1, 16'h0000);
    op(8'h94);
    op({multiply_op, 4'h3});
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n[15:0], 16'h0010);
    if (n >= 40) test_done();
    reg_is(4'h1, 16'hFFFE);
    reg_is(4'h4, 16'h0001);
    reg_is(4'h3, 16'hFFFF);
    reg_is(4'h0, epc);
  endtask
  task automatic t_bad;
    logic [7:0] codes [3] = '{8'h05, 8'h62, 8'hF2};
    foreach (codes[i]) begin
      op(codes[i]);
      chk({15'h0000, op_unhandled}, 16'h0001);
    end
    reg_is(4'h0, epc);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_alu();
    t_port();
    t_branch();
    t_mul();
    t_bad();
    test_done();
  end
endmodule
bind sce_exec sce_exec_checker u_chk(.clk_sys(clk_sys), .rst_b(rst_b),
  .fetch_addr(fetch_addr), .instr_byte(instr_byte), .instr_valid(instr_valid),
  .busy(busy), .op_unhandled(op_unhandled), .port_wr_stb(port_wr_stb),
  .port_wr_idx(port_wr_idx));

// File: sce_mult.sv
// sequential shift-and-add multiplier, one partial product per clock.
// assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ns
`include "sce_consts.svh"

module sce_mult import sce_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // operands
  input wire logic start,
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] m_in,
  input wire logic [W-1:0] n_in,
  // result
  output logic done,
  output logic [W-1:0] hi,
  output logic [W-1:0] lo
);

  localparam int CW = $clog2(W) + 1;

  generate
    if (W < 2) begin : g_bad_width
      $error("sce_mult: width below 2");
    end
  endgenerate

  logic [W-1:0] acc;
  logic [W-1:0] mq;
  logic [W-1:0] mcand;
  logic [CW-1:0] cnt;
  logic run;
  logic [W:0] sum;
  logic last;

  // carry kept in bit W so the shift never loses a product bit
  assign sum = mq[0] ? ({1'b0, acc} + {1'b0, mcand}) : {1'b0, acc};
  assign last = (cnt == CW'(W - 1));

  // iteration datapath; the accumulator seeds the upper word, hence must be zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc <= '0;
      mq <= '0;
      mcand <= '0;
    end else if (start) begin
      acc <= a_in;
      mq <= m_in;
      mcand <= n_in;
    end else if (run) begin
      {acc, mq} <= {sum, mq[W-1:1]};
    end
  end

  // iteration counter; done marks the cycle of the last step
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt <= '0;
      run <= 1'b0;
    end else begin
      if (start) begin
        cnt <= '0;
        run <= 1'b1;
      end else if (run) begin
        cnt <= cnt + CW'(1);
        if (last) begin
          run <= 1'b0;
        end
      end
    end
  end

  // last step folded into the result, so write-back lands with that step
  // instead of one clock later; words are meaningful only while done is high
  assign done = run && last;
  assign hi = sum[W:1];
  assign lo = {sum[0], mq[W-1:1]};

endmodule

// File: sce_pkg.sv
// types of the upper-opcode execution block: opcode and state enumerations.
// assumes sce_consts.svh is on the include path.
`include "sce_consts.svh"

package sce_pkg;

  // upper-nibble operation codes; all but clear_reg_op are handled here
  typedef enum logic [3:0] {
    clear_reg_op = `SCE_OPC_CLEAR,
    arith_shift_right_op = `SCE_OPC_ASR,
    increment_reg_op = `SCE_OPC_INC,
    decrement_reg_op = `SCE_OPC_DEC,
    complement_reg_op = `SCE_OPC_NOT,
    branch_nonnegative_op = `SCE_OPC_BNN,
    branch_nonzero_op = `SCE_OPC_BNZ,
    port_read_op = `SCE_OPC_PRD,
    port_write_op = `SCE_OPC_PWR,
    multiply_op = `SCE_OPC_MUL
  } sce_op_t;

  // execution state, one-hot
  typedef enum logic [1:0] {
    SCE_RUN = 2'b01,
    SCE_MUL = 2'b10
  } sce_state_t;

endpackage

// File: sce_prog_mem.sv
// program memory model: offers the byte at the fetch address while run.
// assumes the bench loads mem and addresses stay below 256.
`timescale 1ns/1ns
module sce_prog_mem(
  // fetch side
  input wire logic [15:0] addr,
  input wire logic run,
  output logic [7:0] ibyte,
  output logic valid
);
  logic [7:0] mem [256];
  // blank flash reads as all ones
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'hFF;
    end
  end
  // inverted when not offered, so a stale byte never looks valid
  assign valid = run;
  assign ibyte = run ? mem[addr[7:0]] : ~mem[addr[7:0]];
endmodule
